// [hw/sled_pkg.sv]
package sled_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_KHZ       = 200_000;
    localparam int unsigned BLINK_MS      = 200;
    localparam int unsigned FLASH_ON_MS   = 200;
    localparam int unsigned FLASH_OFF_MS  = 1000;
    localparam int unsigned FLICKER_MS    = 50;
    localparam int unsigned STEP_US       = 10;
    localparam int unsigned BLINK_CYC     = BLINK_MS * CLK_KHZ;
    localparam int unsigned FLASH_ON_CYC  = FLASH_ON_MS * CLK_KHZ;
    localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CLK_KHZ;
    localparam int unsigned FLICKER_CYC   = FLICKER_MS * CLK_KHZ;
    localparam int unsigned STEP_CYC      = STEP_US * CLK_KHZ / 1000;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [2:0] CTRL_RESET   = 3'h4;
    localparam logic [4:0] MASK_RESET   = 5'h00;
    localparam int unsigned IRQ_W       = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_LOAD   = 3'b000,
        ST_INIT   = 3'b001,
        ST_PREOP  = 3'b010,
        ST_SAFEOP = 3'b011,
        ST_OP     = 3'b100
    } sled_state_t;

    typedef struct packed {
        logic comm_err;
        logic link_up;
        logic activity;
        logic card_access;
        logic unit_err;
        logic unit_warn;
        logic unit_alarm;
    } sled_pins_t;

    typedef struct packed {
        logic power;
        logic comm_state_led;
        logic comm_error_led;
        logic link_activity_led;
        logic card_led;
        logic unit_fault_led;
        logic unit_alarm_led;
        logic reserved_a;
        logic reserved_b;
    } sled_leds_t;

    typedef struct packed {
        logic mailbox;
        logic pdo_s2m;
        logic pdo_m2s;
    } sled_svc_t;

endpackage

// [hw/sled_indicator.sv]
// Behaviour
// - Blue power lamp steadily on while powered.
// - State lamp: off, blink, single flash, on.
// - Red fieldbus error lamp follows communication error.
// - Link lamp flickers while link carries frames.
// - Link lamp steady on when link idle.
// - Link lamp off without physical link.
// - Card lamp on only during card access.
// - Fault lamp: error on, warning blinks, else off.
// - Alarm lamp follows unit alarm.
// - Init blocks mailbox and process data.
// - Pre-Operational allows mailbox only.
// - Safe-Operational: mailbox and slave-to-master data.
// - State steps happen automatically, no user program.
// - Operational: state lamp on, link flag set.
// - Load parameters, start, flag when links up.
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module sled_indicator
#(
    parameter int unsigned BLINK_CYC     = sled_pkg::BLINK_CYC,
    parameter int unsigned FLASH_ON_CYC  = sled_pkg::FLASH_ON_CYC,
    parameter int unsigned FLASH_OFF_CYC = sled_pkg::FLASH_OFF_CYC,
    parameter int unsigned FLICKER_CYC   = sled_pkg::FLICKER_CYC
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              param_ready_i,
    input  wire sled_pkg::sled_pins_t pins_i,
    output sled_pkg::sled_leds_t   leds_o,
    output sled_pkg::sled_svc_t    svc_o,
    output logic                   link_established_flag_o,
    output logic                   irq_o
);
    import sled_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int unsigned PIN_W = $bits(sled_pins_t);

    logic [PIN_W-1:0] sync_a;
    logic [PIN_W-1:0] sync_b;
    sled_pins_t       pin;

    genvar g;
    generate
        for (g = 0; g < PIN_W; g++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end
                else
                begin
                    sync_a[g] <= pins_i[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    assign pin = sync_b;

    // ************************************************************
    // Register decode
    // ************************************************************
    logic [2:0]       ctrl_target;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    sled_state_t      state;
    sled_svc_t        svc;
    // A write takes effect at the edge where the master sees ack.
    wire              bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire              bus_end = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire              bus_wr  = bus_end & wb_we_i & wb_sel_i[0];
    wire              wr_ctrl = bus_wr & (wb_adr_i == REG_CTRL);
    wire              wr_stat = bus_wr & (wb_adr_i == REG_IRQ_STAT);
    wire              wr_mask = bus_wr & (wb_adr_i == REG_IRQ_MASK);
    wire [31:0]       status_word = {24'h000000,
                                     link_established_flag_o,
                                     svc, 1'b0, state};
    wire [31:0]       rd_word =
        (wb_adr_i == REG_CTRL)     ? {29'h0000000, ctrl_target} :
        (wb_adr_i == REG_STATUS)   ? status_word :
        (wb_adr_i == REG_IRQ_STAT) ? {27'h0000000, irq_stat} :
        (wb_adr_i == REG_IRQ_MASK) ? {27'h0000000, irq_mask} :
        32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_target <= CTRL_RESET;
            irq_mask    <= MASK_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_target <= wb_dat_i[2:0];
            end
            if (wr_mask)
            begin
                irq_mask <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // ************************************************************
    // Communication state machine
    // ************************************************************
    sled_state_t next_state;
    logic [31:0] step_cnt;
    wire         step_done = (step_cnt == 32'(STEP_CYC - 1));
    wire         may_rise  = (state != ST_LOAD) && (state < ctrl_target);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_LOAD:   next_state = param_ready_i ? ST_INIT : ST_LOAD;
            ST_INIT:   next_state = ST_PREOP;
            ST_PREOP:  next_state = ST_SAFEOP;
            ST_SAFEOP: next_state = ST_OP;
            ST_OP:     next_state = ST_OP;
            default:   next_state = ST_INIT;
        endcase
        if (state != ST_LOAD && !pin.link_up)
        begin
            next_state = ST_INIT;
        end
        else if (state != ST_LOAD && state > ctrl_target)
        begin
            next_state = sled_state_t'(ctrl_target);
        end
        else if (state != ST_LOAD && !(may_rise && step_done))
        begin
            next_state = state;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state    <= ST_LOAD;
            step_cnt <= 32'h00000000;
        end
        else
        begin
            state    <= next_state;
            step_cnt <= (next_state != state || step_done || !may_rise
                         || !pin.link_up)
                        ? 32'h00000000 : step_cnt + 32'h00000001;
        end
    end

    // ************************************************************
    // Service enables
    // ************************************************************
    always_comb
    begin
        case (state)
            ST_PREOP:  svc = '{1'b1, 1'b0, 1'b0};
            ST_SAFEOP: svc = '{1'b1, 1'b1, 1'b0};
            ST_OP:     svc = '{1'b1, 1'b1, 1'b1};
            default:   svc = '{1'b0, 1'b0, 1'b0};
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            svc_o                   <= '{1'b0, 1'b0, 1'b0};
            link_established_flag_o <= 1'b0;
        end
        else
        begin
            svc_o                   <= svc;
            link_established_flag_o <= (state == ST_OP);
        end
    end

    // ************************************************************
    // Blink, flash and flicker timing
    // ************************************************************
    logic [31:0] blink_cnt;
    logic [31:0] flash_cnt;
    logic [31:0] flick_cnt;
    logic        blink_ph;
    logic        flick_ph;
    logic        act_seen;
    logic        act_prev;
    wire         blink_end = (blink_cnt == 32'(BLINK_CYC - 1));
    wire         flash_end = (flash_cnt ==
                              32'(FLASH_ON_CYC + FLASH_OFF_CYC - 1));
    wire         flick_end = (flick_cnt == 32'(FLICKER_CYC - 1));
    wire         flash_on  = (flash_cnt < 32'(FLASH_ON_CYC));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            blink_cnt <= 32'h00000000;
            flash_cnt <= 32'h00000000;
            flick_cnt <= 32'h00000000;
            blink_ph  <= 1'b1;
            flick_ph  <= 1'b1;
            act_seen  <= 1'b0;
            act_prev  <= 1'b0;
        end
        else
        begin
            blink_cnt <= blink_end ? 32'h00000000 : blink_cnt + 32'h1;
            flash_cnt <= flash_end ? 32'h00000000 : flash_cnt + 32'h1;
            flick_cnt <= flick_end ? 32'h00000000 : flick_cnt + 32'h1;
            if (blink_end)
            begin
                blink_ph <= ~blink_ph;
            end
            // Activity in this or the previous flicker period keeps the
            // lamp flickering, so that short frames still show.
            if (flick_end)
            begin
                flick_ph <= ~flick_ph;
                act_prev <= act_seen | pin.activity;
                act_seen <= 1'b0;
            end
            else if (pin.activity)
            begin
                act_seen <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Indicator drive
    // ************************************************************
    sled_leds_t leds;
    wire        run_led =
        (state == ST_PREOP)  ? blink_ph :
        (state == ST_SAFEOP) ? flash_on :
        (state == ST_OP);
    wire        la_led =
        !pin.link_up ? 1'b0 :
        (act_seen | act_prev) ? flick_ph :
        1'b1;
    wire        fault_led =
        pin.unit_err  ? 1'b1 :
        pin.unit_warn ? blink_ph : 1'b0;

    assign leds.power             = 1'b1;
    assign leds.comm_state_led    = run_led;
    assign leds.comm_error_led    = pin.comm_err;
    assign leds.link_activity_led = la_led;
    assign leds.card_led          = pin.card_access;
    assign leds.unit_fault_led    = fault_led;
    assign leds.unit_alarm_led    = pin.unit_alarm;
    assign leds.reserved_a        = 1'b0;
    assign leds.reserved_b        = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            leds_o <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                        1'b0, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            leds_o <= leds;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    sled_state_t      prev_state;
    logic             prev_err;
    logic             prev_link;
    logic             prev_fault;
    logic             prev_alarm;
    wire [IRQ_W-1:0]  irq_evt = {
        pin.unit_alarm & ~prev_alarm,
        pin.unit_err & ~prev_fault,
        prev_link & ~pin.link_up,
        pin.comm_err & ~prev_err,
        state != prev_state
    };
    wire [IRQ_W-1:0]  irq_clr = wr_stat ? wb_dat_i[IRQ_W-1:0]
                                        : {IRQ_W{1'b0}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_state <= ST_LOAD;
            prev_err   <= 1'b0;
            prev_link  <= 1'b0;
            prev_fault <= 1'b0;
            prev_alarm <= 1'b0;
            irq_stat   <= {IRQ_W{1'b0}};
            irq_o      <= 1'b0;
        end
        else
        begin
            prev_state <= state;
            prev_err   <= pin.comm_err;
            prev_link  <= pin.link_up;
            prev_fault <= pin.unit_err;
            prev_alarm <= pin.unit_alarm;
            // A new event wins over a clear in the same cycle.
            irq_stat   <= (irq_stat & ~irq_clr) | irq_evt;
            irq_o      <= |(irq_stat & irq_mask);
        end
    end

endmodule // sled_indicator

`default_nettype wire

// [testbench/sled_indicator_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module sled_indicator_sva
(
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire sled_pkg::sled_pins_t pins_i,
    input wire sled_pkg::sled_leds_t leds_o,
    input wire sled_pkg::sled_svc_t  svc_o,
    input wire logic                 link_established_flag_o
);
    import sled_pkg::*;
    logic [2:0] settle;
    wire        ok = settle == 3'h7;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            settle <= 3'h0;
        else if (!ok)
            settle <= settle + 3'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_lost;
        ok && $fell(pins_i.link_up);
    endsequence
    property p_power; leds_o.power; endproperty
    property p_rsv; !leds_o.reserved_a && !leds_o.reserved_b; endproperty
    property p_svc; svc_o inside {3'h0, 3'h4, 3'h6, 3'h7}; endproperty
    property p_op;
        link_established_flag_o |-> svc_o == 3'h7 && leds_o.comm_state_led;
    endproperty
    property p_init;
        svc_o == 3'h0 |-> !leds_o.comm_state_led && !link_established_flag_o;
    endproperty
    property p_err;
        ok |-> leds_o.comm_error_led == $past(pins_i.comm_err, 3);
    endproperty
    property p_card;
        ok |-> leds_o.card_led == $past(pins_i.card_access, 3);
    endproperty
    property p_alm;
        ok |-> leds_o.unit_alarm_led == $past(pins_i.unit_alarm, 3);
    endproperty
    property p_fault;
        ok && $past(pins_i.unit_err, 3) |-> leds_o.unit_fault_led;
    endproperty
    property p_nolink;
        ok && !$past(pins_i.link_up, 3) |-> !leds_o.link_activity_led;
    endproperty
    property p_drop;
        s_lost |-> ##[1:5] !link_established_flag_o && svc_o == 3'h0;
    endproperty
    a_power: assert property (p_power) else $error("power lamp off");
    a_rsv: assert property (p_rsv) else $error("reserved lamp lit");
    a_svc: assert property (p_svc) else $error("bad service set");
    a_op: assert property (p_op) else $error("flag without op");
    a_init: assert property (p_init) else $error("state lamp in init");
    a_err: assert property (p_err) else $error("error lamp wrong");
    a_card: assert property (p_card) else $error("card lamp wrong");
    a_alm: assert property (p_alm) else $error("alarm lamp wrong");
    a_fault: assert property (p_fault) else $error("fault lamp off");
    a_nolink: assert property (p_nolink) else $error("link lamp lit");
    a_drop: assert property (p_drop) else $error("flag kept");
endmodule // sled_indicator_sva
bind sled_indicator sled_indicator_sva u_sled_indicator_sva
(
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .pins_i                  (pins_i),
    .leds_o                  (leds_o),
    .svc_o                   (svc_o),
    .link_established_flag_o (link_established_flag_o)
);
`default_nettype wire

// [testbench/sled_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sled_far_model
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           link_req_i,
    input  wire logic           traffic_i,
    input  wire logic [4:0]     fault_i,
    output logic                param_ready_o,
    output sled_pkg::sled_pins_t pins_o
);
    import sled_pkg::*;
    logic [3:0] load_cnt;
    logic       act;
    // Parameters come up a few cycles after reset, unprompted.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            load_cnt <= 4'h0;
        else if (load_cnt != 4'hF)
            load_cnt <= load_cnt + 4'h1;
    end
    assign param_ready_o = load_cnt > 4'h9;
    // Frames only move while the link is up.
    always_ff @(posedge clk_i)
    begin
        act <= traffic_i & link_req_i & ~act;
    end
    assign pins_o.comm_err    = fault_i[4];
    assign pins_o.link_up     = link_req_i;
    assign pins_o.activity    = act;
    assign pins_o.card_access = fault_i[3];
    assign pins_o.unit_err    = fault_i[2];
    assign pins_o.unit_warn   = fault_i[1];
    assign pins_o.unit_alarm  = fault_i[0];
endmodule // sled_far_model
`default_nettype wire

// [testbench/sled_indicator_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module sled_indicator_tb;
    import sled_pkg::*;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, link_req, traffic;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_q, q;
    logic wb_ack, param_ready, flag, irq;
    logic [4:0] fault;
    sled_pins_t pins;
    sled_leds_t leds;
    sled_svc_t svc;
    int num_errors, cmp_count, h;
    sled_indicator #(.BLINK_CYC(8), .FLASH_ON_CYC(8), .FLASH_OFF_CYC(40),
        .FLICKER_CYC(4)) u_sled_indicator (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .param_ready_i(param_ready),
        .pins_i(pins), .leds_o(leds), .svc_o(svc),
        .link_established_flag_o(flag), .irq_o(irq));
    sled_far_model u_sled_far_model (.clk_i(clk_i), .rst_i(rst_i),
        .link_req_i(link_req), .traffic_i(traffic), .fault_i(fault),
        .param_ready_o(param_ready), .pins_o(pins));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("ack", 1, wb_ack);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk("reg", e, q);
    endtask
    task automatic cnt(input int i, input int len);
        h = 0;
        repeat (len) @(negedge clk_i) h += int'(leds[i]);
    endtask
    task automatic t_reset();
        chk("leds", 32'h100, leds);
        chk("svc", 32'h0, {flag, irq, svc});
        rd(REG_CTRL, 32'h4);
        rd(REG_IRQ_MASK, 32'h0);
        rd(8'h10, 32'h0);
    endtask
    task automatic t_states();
        logic [2:0] es[3] = '{3'h4, 3'h6, 3'h7};
        logic [7:0] st[3] = '{8'h42, 8'h63, 8'hF4};
        int ln[3] = '{32, 48, 16}, hi[3] = '{16, 8, 16};
        link_req <= 1'b1;
        repeat (20) @(posedge clk_i);
        rd(REG_STATUS, 32'h01);
        for (int k = 0; k < 3; k++)
        begin
            h = 0;
            while (svc !== es[k] && h < 3000) @(negedge clk_i) h++;
            chk("svc", es[k], svc);
            rd(REG_STATUS, st[k]);
            cnt(7, ln[k]);
            chk("state lamp", hi[k], h);
        end
    endtask
    task automatic t_ctrl();
        wb(1'b1, REG_CTRL, 32'h3);
        rd(REG_CTRL, 32'h3);
        h = 0;
        while (svc !== 3'h6 && h < 10) @(negedge clk_i) h++;
        chk("svc drop", 3'h6, svc);
        wb(1'b1, REG_CTRL, 32'h4);
        h = 0;
        while (svc !== 3'h7 && h < 3000) @(negedge clk_i) h++;
        chk("svc rise", 3'h7, svc);
    endtask
    task automatic t_pins();
        logic [8:0] ex[5] = '{9'h1A4, 9'h1A0, 9'h1A8, 9'h1B0, 9'h1E0};
        cnt(5, 16);
        chk("idle link", 16, h);
        @(posedge clk_i);
        traffic <= 1'b1;
        cnt(5, 16);
        chk("flicker", 1, h > 0 && h < 16);
        @(posedge clk_i);
        traffic <= 1'b0;
        repeat (20) @(posedge clk_i);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk_i);
            fault <= 5'h1 << k;
            repeat (5) @(negedge clk_i);
            if (k != 1) chk("leds", ex[k], leds);
            else cnt(3, 32);
            if (k == 1) chk("warn blink", 16, h);
        end
        @(posedge clk_i);
        fault <= 5'h06;
        repeat (4) @(negedge clk_i);
        cnt(3, 32);
        chk("err wins", 32, h);
        @(posedge clk_i);
        fault <= 5'h0;
    endtask
    task automatic t_irq();
        wb(1'b1, REG_IRQ_STAT, 32'h1F);
        rd(REG_IRQ_STAT, 32'h0);
        wb(1'b1, REG_IRQ_MASK, 32'h04);
        @(negedge clk_i);
        chk("irq", 0, irq);
        @(posedge clk_i);
        link_req <= 1'b0;
        repeat (8) @(negedge clk_i);
        chk("drop", 32'h08, {leds.link_activity_led, flag, irq, svc});
        wb(1'b1, REG_IRQ_MASK, 32'h0);
        repeat (2) @(negedge clk_i);
        chk("irq", 0, irq);
        rd(REG_IRQ_STAT, 32'h05);
        wb(1'b1, REG_IRQ_STAT, 32'h1F);
        rd(REG_IRQ_STAT, 32'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial
    begin
        {wb_cyc, wb_stb, wb_we, link_req, traffic} = 5'h0;
        {wb_adr, wb_dat, fault} = '0;
        wb_sel = 4'hF;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_states();
        t_ctrl();
        t_pins();
        t_irq();
        complete_run();
    end
endmodule // sled_indicator_tb
`default_nettype wire
